// [src/burst_read_pkg.sv]
// Constants, register layout and states of the clocked burst read control
`default_nettype none
package burst_read_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam int WIN_AW = 13;
    localparam logic [WIN_AW-1:0] CTRL_OFFSET = 13'h101C;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_EDGE = 1;
    localparam int BIT_HOLD = 2;
    localparam int DELAY_LSB = 8;
    localparam int DELAY_W = 4;
    localparam int SIZE_LSB = 12;
    localparam int SIZE_W = 4;
    localparam logic [15:0] CTRL_WMASK = 16'hFF07;
    localparam logic [SIZE_W-1:0] SIZE_MAX = 4'hA;
    localparam logic [4:0] DELAY_BASE = 5'h02;
    // ************************************************************
    // Burst sequencer
    // ************************************************************
    localparam int UNIT_W = 16;
    typedef enum logic [1:0] {ST_IDLE, ST_LAT, ST_DATA} burst_state_e;
endpackage
`default_nettype wire

// [src/pin_sync.sv]
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins in, levels out
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // ************************************************************
    // One synchroniser per bit
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    meta_ff[g] <= 1'b1;
                    sync_ff[g] <= 1'b1;
                end
                else
                begin
                    meta_ff[g] <= pin_i[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_ff;
endmodule // pin_sync
`default_nettype wire

// [src/edge_find.sv]
// Rising and falling edge pulses of a synchronised level
`timescale 1ns/100ps
`default_nettype none
module edge_find (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Synchronised level in, pulses out
    input wire logic level_i,
    output logic rise_o,
    output logic fall_o
);
    logic last_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            last_ff <= 1'b1;
        else
            last_ff <= level_i;
    end

    assign rise_o = level_i & ~last_ff;
    assign fall_o = ~level_i & last_ff;
endmodule // edge_find
`default_nettype wire

// [src/burst_read_control.sv]
// Burst read control: register slave, strobe timing and burst sequencer
`timescale 1ns/100ps
`default_nettype none
module burst_read_control (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [12:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Host port pins
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic burst_clk_i,
    input wire logic if_word_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    // Word source and strobe timing
    input wire logic [15:0] word_data_i,
    output logic word_take_o,
    output logic strobe_rd_o,
    output logic strobe_wr_o,
    output logic burst_busy_o
);
    // ************************************************************
    // Declarations
    // ************************************************************
    localparam int SIZE_W_L = burst_read_pkg::SIZE_W;
    localparam int UNIT_W_L = burst_read_pkg::UNIT_W;
    logic [15:0] ctrl_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [4:0] pins_s;
    logic ce_s;
    logic oe_s;
    logic we_s;
    logic clk_s;
    logic word_s;
    logic clk_rise;
    logic clk_fall;
    logic sel_rise;
    logic sel_fall;
    logic we_rise;
    logic we_fall;
    logic sample_evt;
    logic access_on;
    logic burst_en;
    logic hold_en;
    logic [SIZE_W_L-1:0] size_eff;
    logic [3:0] shift_amt;
    logic [UNIT_W_L-1:0] unit_limit;
    burst_read_pkg::burst_state_e state_ff;
    logic [4:0] lat_ff;
    logic [UNIT_W_L-1:0] units_ff;
    logic phase_ff;
    logic [15:0] data_ff;
    logic oe_ff;
    logic take_ff;
    logic rd_ff;
    logic wr_ff;
    logic hit;
    logic req;
    logic last_unit;

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    // Window decode: every offset of the 8KB window answers
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign hit = (wb_adr_i == burst_read_pkg::CTRL_OFFSET);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= req;
    end

    // Write lands on the edge that sees ack high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_ff <= burst_read_pkg::CTRL_RESET;
        else if (wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && hit)
        begin
            if (wb_sel_i[0])
                ctrl_ff[7:0] <= wb_dat_i[7:0] & burst_read_pkg::CTRL_WMASK[7:0];
            if (wb_sel_i[1])
                ctrl_ff[15:8] <= wb_dat_i[15:8];
        end
    end

    // Unmapped offsets read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdat_ff <= 32'h00000000;
        else if (req && hit && !wb_we_i)
            rdat_ff <= {16'h0000, ctrl_ff};
        else
            rdat_ff <= 32'h00000000;
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // ************************************************************
    // Pin synchronisers and edge finders
    // ************************************************************
    pin_sync #(
        .W(5)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({if_word_i, ~burst_clk_i, we_n_i, oe_n_i, ce_n_i}),
        .sync_o(pins_s)
    );

    assign ce_s = ~pins_s[0];
    assign oe_s = ~pins_s[1];
    assign we_s = ~pins_s[2];
    assign clk_s = ~pins_s[3];
    assign word_s = pins_s[4];
    assign access_on = ce_s & oe_s;

    edge_find u_clk_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(~clk_s),
        .rise_o(clk_fall),
        .fall_o(clk_rise)
    );

    edge_find u_rd_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(~access_on),
        .rise_o(sel_rise),
        .fall_o(sel_fall)
    );

    edge_find u_wr_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(~(ce_s & we_s)),
        .rise_o(we_rise),
        .fall_o(we_fall)
    );

    // ************************************************************
    // Configuration decode
    // ************************************************************
    assign burst_en = ctrl_ff[burst_read_pkg::BIT_ENABLE];
    assign hold_en = ctrl_ff[burst_read_pkg::BIT_HOLD];

    // Clock edges only count while enabled; the pin may float otherwise
    always_comb
    begin
        if (!burst_en)
            sample_evt = 1'b0;
        else if (ctrl_ff[burst_read_pkg::BIT_EDGE])
            sample_evt = clk_fall;
        else
            sample_evt = clk_rise;
    end

    // Out of range sizes clamp so the counter cannot overflow
    assign size_eff = (ctrl_ff[burst_read_pkg::SIZE_LSB +: SIZE_W_L] > burst_read_pkg::SIZE_MAX)
        ? burst_read_pkg::SIZE_MAX
        : ctrl_ff[burst_read_pkg::SIZE_LSB +: SIZE_W_L];

    always_comb
    begin
        if (hold_en && size_eff != 4'h0)
            shift_amt = size_eff - 4'h1;
        else if (hold_en)
            shift_amt = 4'h0;
        else
            shift_amt = size_eff;
    end

    assign unit_limit = UNIT_W_L'(1) << shift_amt;
    assign last_unit = (units_ff == unit_limit - UNIT_W_L'(1));

    // ************************************************************
    // Burst sequencer
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_ff <= burst_read_pkg::ST_IDLE;
        else if (!burst_en)
            state_ff <= burst_read_pkg::ST_IDLE;
        else
        begin
            case (state_ff)
                burst_read_pkg::ST_IDLE:
                begin
                    // Every read is a burst once enabled
                    if (sample_evt && access_on)
                        state_ff <= burst_read_pkg::ST_LAT;
                end
                burst_read_pkg::ST_LAT:
                begin
                    if (!access_on)
                        state_ff <= burst_read_pkg::ST_IDLE;
                    else if (sample_evt && lat_ff == 5'h01)
                        state_ff <= burst_read_pkg::ST_DATA;
                end
                burst_read_pkg::ST_DATA:
                begin
                    if (!access_on)
                        state_ff <= burst_read_pkg::ST_IDLE;
                    else if (sample_evt && (phase_ff || !hold_en) && last_unit)
                        state_ff <= burst_read_pkg::ST_IDLE;
                end
                default:
                    state_ff <= burst_read_pkg::ST_IDLE;
            endcase
        end
    end

    // Word launched one edge early so the host can latch it on edge two plus delay
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            lat_ff <= 5'h00;
        else if (state_ff == burst_read_pkg::ST_IDLE)
            lat_ff <= burst_read_pkg::DELAY_BASE - 5'h01
                + {1'b0, ctrl_ff[burst_read_pkg::DELAY_LSB +: burst_read_pkg::DELAY_W]};
        else if (state_ff == burst_read_pkg::ST_LAT && sample_evt)
            lat_ff <= lat_ff - 5'h01;
    end

    // Hold phase: each word stays for one or two sample edges
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            phase_ff <= 1'b0;
        else if (state_ff != burst_read_pkg::ST_DATA)
            phase_ff <= 1'b0;
        else if (sample_evt && hold_en)
            phase_ff <= ~phase_ff;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            units_ff <= '0;
        else if (state_ff != burst_read_pkg::ST_DATA)
            units_ff <= '0;
        else if (sample_evt && (phase_ff || !hold_en))
            units_ff <= units_ff + UNIT_W_L'(1);
    end

    // Next word loads on entry and on each completed hold
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            take_ff <= 1'b0;
        else
            take_ff <= access_on && sample_evt
                && ((state_ff == burst_read_pkg::ST_LAT && lat_ff == 5'h01)
                || (state_ff == burst_read_pkg::ST_DATA && (phase_ff || !hold_en)
                && !last_unit));
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            data_ff <= 16'h0000;
        else if (take_ff)
        begin
            // Byte wide port: units are bytes on the low lane
            if (word_s)
                data_ff <= word_data_i;
            else
                data_ff <= {8'h00, word_data_i[7:0]};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            oe_ff <= 1'b0;
        else if (state_ff != burst_read_pkg::ST_DATA || !access_on || !burst_en)
            oe_ff <= 1'b0;
        else if (take_ff)
            oe_ff <= 1'b1;
    end

    assign data_o = data_ff;
    assign data_oe_o = oe_ff;
    assign word_take_o = take_ff;
    assign burst_busy_o = (state_ff != burst_read_pkg::ST_IDLE);

    // ************************************************************
    // Strobe timing outside bursts
    // ************************************************************
    // Strobe edges stand in for a clock when bursts are off
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
        end
        else
        begin
            rd_ff <= !burst_en && sel_fall;
            wr_ff <= !burst_en && we_rise;
        end
    end

    assign strobe_rd_o = rd_ff;
    assign strobe_wr_o = wr_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_DISABLED_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        !burst_en |=> state_ff == burst_read_pkg::ST_IDLE && !oe_ff)
        else $error("burst active while disabled");

    AST_START: assert property (@(posedge clk_i) disable iff (rst_i)
        burst_en && state_ff == burst_read_pkg::ST_IDLE && sample_evt && access_on
        |=> state_ff == burst_read_pkg::ST_LAT)
        else $error("enabled read did not start a burst");

    AST_EDGE_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_evt |-> (ctrl_ff[burst_read_pkg::BIT_EDGE]
            ? (!clk_s && $past(clk_s)) : (clk_s && !$past(clk_s))))
        else $error("wrong sampling edge");

    AST_LAT_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == burst_read_pkg::ST_LAT && access_on && sample_evt && lat_ff == 5'h01
        |=> take_ff ##1 oe_ff)
        else $error("first word late");

    AST_HOLD_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
        hold_en && state_ff == burst_read_pkg::ST_DATA && sample_evt && !phase_ff
        |=> !take_ff)
        else $error("word changed inside hold");

    AST_UNIT_LIMIT: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == burst_read_pkg::ST_DATA |-> units_ff < unit_limit)
        else $error("burst ran past its length");

    AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_ff |-> wb_dat_o[7:3] == 5'h00 && wb_dat_o[31:16] == 16'h0000)
        else $error("reserved bits not zero");

    AST_BYTE_LANE: assert property (@(posedge clk_i) disable iff (rst_i)
        oe_ff && !word_s && $stable(word_s) |-> data_ff[15:8] == 8'h00)
        else $error("upper lane driven in byte mode");

    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> ack_ff ##1 !ack_ff)
        else $error("window access not answered once");

    AST_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff != burst_read_pkg::ST_IDLE && !access_on
        |=> state_ff == burst_read_pkg::ST_IDLE ##1 !oe_ff)
        else $error("burst kept after strobe release");

    AST_STROBE_ASYNC: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_ff || wr_ff |-> !$past(burst_en))
        else $error("strobe timing used during burst mode");
endmodule // burst_read_control
`default_nettype wire

// [verification/host_model.sv]
// Host side model: strobes and burst clock of a memory controller
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Host strobes and clock
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic burst_clk_o,
    // Device data pins
    input wire logic [15:0] data_i,
    input wire logic data_oe_i
);
    int n_oe = 0;
    int first = -1;
    logic [15:0] words [0:3];
    initial
    begin
        ce_n_o = 1'b1;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
        burst_clk_o = 1'b0; // Clock stands still outside frames
    end
    // ****
    // Latching at the sample edge
    // ****
    // A real host latches nothing once its strobes are gone
    task automatic latch(input int k);
        if (data_oe_i === 1'b1 && ce_n_o === 1'b0)
        begin
            if (first < 0)
                first = k;
            if (n_oe < 4)
                words[n_oe] = data_i;
            n_oe++;
        end
    endtask
    // Read frame of n periods, strobes dropped before period rel
    task automatic burst(input logic fall, input int n, input int rel);
        n_oe = 0;
        first = -1;
        #13;
        ce_n_o = 1'b0;
        oe_n_o = 1'b0;
        for (int k = 0; k < n; k++)
        begin
            if (k == rel)
            begin
                ce_n_o = 1'b1;
                oe_n_o = 1'b1;
            end
            #160 burst_clk_o = 1'b1;
            if (!fall)
                latch(k);
            #160 burst_clk_o = 1'b0;
            if (fall)
                latch(k);
        end
        ce_n_o = 1'b1;
        oe_n_o = 1'b1;
        #800;
    endtask
    // Plain strobed write, no burst clock
    task automatic write_pulse();
        #13;
        ce_n_o = 1'b0;
        we_n_o = 1'b0;
        #200;
        ce_n_o = 1'b1;
        we_n_o = 1'b1;
        #400;
    endtask
endmodule // host_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the burst read control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module testbench;
    logic clk_i, rst_i, cyc, stb, we, ack, ce_n, oe_n, we_n, bclk, if_word;
    logic data_oe, take, srd, swr, busy;
    logic [12:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [15:0] data, word_data;
    int fails = 0;
    int n_tests = 0;
    int takes = 0;
    int rds = 0;
    int wrs = 0;
    localparam logic [12:0] REG = burst_read_pkg::CTRL_OFFSET;
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Word source advances on each take pulse
    always @(posedge clk_i)
    begin
        if (take === 1'b1)
        begin
            word_data <= word_data + 16'h0001;
            takes <= takes + 1;
        end
        if (srd === 1'b1)
            rds <= rds + 1;
        if (swr === 1'b1)
            wrs <= wrs + 1;
    end
    burst_read_control dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .burst_clk_i(bclk),
        .if_word_i(if_word), .data_o(data), .data_oe_o(data_oe), .word_data_i(word_data),
        .word_take_o(take), .strobe_rd_o(srd), .strobe_wr_o(swr), .burst_busy_o(busy));
    host_model host (.ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .burst_clk_o(bclk),
        .data_i(data), .data_oe_i(data_oe));
    // ****
    // Bus and closing tasks
    // ****
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Ack sampled at the rising edge; data taken and request released at that edge
    task automatic wb_xfer(input logic w, input logic [12:0] a, input logic [15:0] d,
        output logic [15:0] q);
        int i;
        i = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do
        begin
            @(posedge clk_i);
            i++;
        end
        while (ack !== 1'b1 && i < 50);
        if (ack !== 1'b1)
        begin
            fails++;
            wrap_up();
        end
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic reg_wr(input logic [12:0] a, input logic [15:0] d);
        logic [15:0] q;
        wb_xfer(1'b1, a, d, q);
    endtask
    task automatic reg_chk(input string nm, input logic [12:0] a, input logic [15:0] e);
        logic [15:0] q;
        wb_xfer(1'b0, a, 16'h0000, q);
        `CHK(nm, e, q)
    endtask
    task automatic run_burst(input string nm, input logic [15:0] cfg, input int n,
        input int rel, input int e_first, input int e_oe, input int e_takes);
        int t0;
        logic [15:0] w0;
        reg_wr(REG, cfg);
        t0 = takes;
        w0 = word_data;
        host.burst(cfg[1], n, rel);
        `CHK({nm, " first"}, e_first, host.first)
        `CHK({nm, " edges"}, e_oe, host.n_oe)
        if (e_takes >= 0)
            `CHK({nm, " units"}, e_takes, takes - t0)
        if (e_oe > 0)
            `CHK({nm, " word"}, if_word ? w0 : {8'h00, w0[7:0]}, host.words[0])
        `CHK({nm, " oe"}, 1'b0, data_oe)
        `CHK({nm, " idle"}, 1'b0, busy)
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs();
        reg_chk("reset", REG, 16'h0000);
        reg_wr(REG, 16'hFFFF);
        reg_chk("reserved", REG, 16'hFF07);
        reg_wr(13'h0000, 16'h0000);
        reg_chk("other write", REG, 16'hFF07);
        reg_chk("other read", 13'h1FFE, 16'h0000);
    endtask
    task automatic t_disabled();
        int r0;
        int w0;
        r0 = rds;
        w0 = wrs;
        run_burst("off", 16'h1000, 8, 99, -1, 0, 0);
        `CHK("rd strobe", r0 + 1, rds)
        host.write_pulse();
        `CHK("wr strobe", w0 + 1, wrs)
    endtask
    task automatic t_basic();
        int r0;
        r0 = rds;
        run_burst("basic", 16'h1001, 5, 99, 2, 2, 2);
        `CHK("no rd strobe", r0, rds)
    endtask
    task automatic t_delay();
        run_burst("delay", 16'h0201, 6, 99, 4, 1, 1);
    endtask
    task automatic t_fall();
        run_burst("fall", 16'h2103, 8, 99, 3, 4, 4);
    endtask
    task automatic t_hold();
        run_burst("hold", 16'h2005, 7, 99, 2, 4, 2);
        `CHK("hold twice", host.words[0], host.words[1])
        `CHK("hold next", host.words[0] + 16'h0001, host.words[2])
    endtask
    task automatic t_release();
        run_burst("release", 16'h3001, 8, 5, 2, 3, 4);
    endtask
    // Byte wide port: only the low lane carries the unit
    task automatic t_byte();
        @(posedge clk_i);
        if_word <= 1'b0;
        repeat (4) @(posedge clk_i);
        run_burst("byte", 16'h1001, 5, 99, 2, 2, 2);
        @(posedge clk_i);
        if_word <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic t_longest();
        run_burst("longest", 16'hA001, 1027, 9999, 2, 1024, 1024);
    endtask
    initial
    begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 13'h0000;
        sel = 4'h3;
        wdat = 32'h00000000;
        if_word = 1'b1;
        word_data = 16'hA5C0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_regs();
        t_disabled();
        t_basic();
        t_delay();
        t_fall();
        t_hold();
        t_release();
        t_byte();
        t_longest();
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
